// ### hdl/file_register_unary_ops.sv
// Execution core for single-operand file and accumulator instructions
// Notes on behaviour
// RQ1 - Complement writes inverted file value to accumulator or file, updates zero flag.
// RQ2 - Clear-file writes zero to the addressed file register and sets zero flag.
// RQ3 - Clear-accumulator writes zero to the accumulator and sets zero flag.
// RQ4 - Decrement writes file minus one to accumulator or file, updates zero flag.
// RQ5 - Decrement-skip writes file minus one to chosen destination, flags unchanged.
// RQ6 - Zero decrement-skip result discards next instruction; an idle slot runs instead.
// RQ7 - Nonzero skip result lets next instruction run; operation takes one cycle.
// RQ8 - Increment-skip writes file plus one to chosen destination, flags unchanged.
// RQ9 - Increment-skip wrapping to zero replaces next instruction with an idle slot.
// RQ10 - Seven-bit file address, one-bit destination, zero flag means result equals zero.
`timescale 1ns/1ps
module file_register_unary_ops #(
	parameter int DATA_W = unary_ops_pkg::DATA_W,
	parameter int ADDR_W = unary_ops_pkg::ADDR_W,
	parameter int FILE_DEPTH = unary_ops_pkg::FILE_DEPTH
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Instruction issue, one per cycle while ready
	input wire logic issue_i,
	input wire unary_ops_pkg::op_e op_i,
	input wire logic [ADDR_W-1:0] file_addr_i,
	input wire logic dest_i,
	// Preload port for the file registers
	input wire logic load_en_i,
	input wire logic [ADDR_W-1:0] load_addr_i,
	input wire logic [DATA_W-1:0] load_data_i,
	// Observation port for the file registers
	input wire logic [ADDR_W-1:0] peek_addr_i,
	output logic [DATA_W-1:0] peek_data_o,
	// Core state and per-instruction results
	output logic ready_o,
	output logic [DATA_W-1:0] acc_o,
	output logic zero_flag_o,
	output logic [DATA_W-1:0] result_o,
	output logic result_valid_o,
	output logic idle_slot_o
);

	// File register storage, no reset as in a real register bank
	// Contents are unknown after power-up, so preload before use
	logic [DATA_W-1:0] file_mem [FILE_DEPTH];

	// Sequencer state
	unary_ops_pkg::exec_state_e state_ff;
	unary_ops_pkg::exec_state_e nxt_state;
	logic nxt_ready;
	logic nxt_idle_slot;
	logic ready_ff;
	logic idle_slot_ff;

	// Accumulator and zero flag
	logic [DATA_W-1:0] acc_ff;
	logic zero_ff;

	// Per-instruction echo and observation
	logic [DATA_W-1:0] result_ff;
	logic result_valid_ff;
	logic [DATA_W-1:0] peek_ff;

	// Take condition and gated write enables
	logic exec_now;
	logic acc_we;
	logic zero_we;
	logic file_we;
	logic skip_taken;

	unary_alu_if alu_bus ();

	// Arithmetic and steering decode, purely combinational
	unary_alu u_alu (
		.alu(alu_bus.calc)
	);

	// An instruction is taken only outside the idle slot
	// A refused issue still shows on issue_i and is simply ignored
	assign exec_now = issue_i && (state_ff == unary_ops_pkg::ST_RUN);

	// RQ10 operand fetched by seven-bit address
	assign alu_bus.operand = file_mem[file_addr_i];
	assign alu_bus.op = op_i;
	assign alu_bus.dest = dest_i;

	// Every write is gated by the take, so a refused issue changes nothing
	assign acc_we = exec_now && alu_bus.write_acc;
	assign zero_we = exec_now && alu_bus.update_zero;
	assign file_we = exec_now && alu_bus.write_file;

	// Only a taken skip with a zero result may open the idle slot
	assign skip_taken = exec_now && alu_bus.skip;

	// Sequencer: an idle slot follows a taken skip
	// Two states suffice, since nothing is taken inside the idle slot
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			unary_ops_pkg::ST_RUN: begin
				// RQ6 enter idle slot
				if (skip_taken) begin
					nxt_state = unary_ops_pkg::ST_IDLE_SLOT;
				// RQ7 no skip, stay running
				end else begin
					nxt_state = unary_ops_pkg::ST_RUN;
				end
			end
			unary_ops_pkg::ST_IDLE_SLOT: begin
				// The discarded instruction's slot lasts exactly one cycle
				nxt_state = unary_ops_pkg::ST_RUN;
			end
			default: begin
				nxt_state = unary_ops_pkg::ST_RUN;
			end
		endcase
	end

	// State register; reset returns to running
	// so the first issue after release is taken
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_ff <= unary_ops_pkg::ST_RUN;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Next-state views feeding the output flops
	assign nxt_ready = (nxt_state == unary_ops_pkg::ST_RUN);
	assign nxt_idle_slot = (nxt_state == unary_ops_pkg::ST_IDLE_SLOT);

	// RQ9 idle slot marker, also for wrap
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			idle_slot_ff <= 1'b0;
		end else begin
			idle_slot_ff <= nxt_idle_slot;
		end
	end

	// Ready mirrors the next state so the output stays a flop
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ready_ff <= 1'b1;
		end else begin
			ready_ff <= nxt_ready;
		end
	end

	// Accumulator keeps its value on file-destination ops
	// RQ1 accumulator destination write
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			acc_ff <= unary_ops_pkg::ACC_RESET;
		// RQ3 clears land here too
		end else if (acc_we) begin
			acc_ff <= alu_bus.result;
		end
	end

	// Flag only moves when the decode asks for it
	// RQ5 skip forms leave the zero flag alone
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			zero_ff <= unary_ops_pkg::ZERO_FLAG_RESET;
		end else if (zero_we) begin
			// RQ2 clears always yield zero
			zero_ff <= alu_bus.result_zero;
		end
	end

	// Clear-file ignores dest_i and always writes the file
	// RQ4 file destination write; instruction beats preload
	always_ff @(posedge clk_i) begin
		// RQ8 skip results written back too
		if (file_we) begin
			file_mem[file_addr_i] <= alu_bus.result;
		end else if (load_en_i) begin
			file_mem[load_addr_i] <= load_data_i;
		end
	end

	// Result value stands until the next take
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			result_ff <= unary_ops_pkg::ZERO_BYTE;
		end else if (exec_now) begin
			result_ff <= alu_bus.result;
		end
	end

	// One-cycle valid pulse per taken instruction
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			result_valid_ff <= 1'b0;
		end else begin
			result_valid_ff <= exec_now;
		end
	end

	// Registered peek, one cycle behind the address
	// A same-edge write shows only on the next peek
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			peek_ff <= unary_ops_pkg::ZERO_BYTE;
		end else begin
			peek_ff <= file_mem[peek_addr_i];
		end
	end

	// Sequencer outputs
	assign ready_o = ready_ff;
	assign idle_slot_o = idle_slot_ff;

	// Architectural and echo outputs
	assign acc_o = acc_ff;
	assign zero_flag_o = zero_ff;
	assign result_o = result_ff;
	assign result_valid_o = result_valid_ff;

	// Observation output
	assign peek_data_o = peek_ff;

endmodule

// ### hdl/unary_alu.sv
// Combinational result, steering and skip decode for the unary operations
`timescale 1ns/1ps
module unary_alu (
	unary_alu_if.calc alu
);

	// Result value and write steering per operation
	always_comb begin
		alu.result = unary_ops_pkg::ZERO_BYTE;
		alu.write_acc = 1'b0;
		alu.write_file = 1'b0;
		alu.update_zero = 1'b0;
		alu.skip = 1'b0;
		case (alu.op)
			// RQ1 invert the operand
			unary_ops_pkg::complement_file_op: begin
				alu.result = ~alu.operand;
				alu.write_acc = (alu.dest == unary_ops_pkg::DEST_ACC);
				alu.write_file = (alu.dest == unary_ops_pkg::DEST_FILE);
				alu.update_zero = 1'b1;
			end
			// RQ2 zero the file register
			unary_ops_pkg::clear_file_op: begin
				alu.result = unary_ops_pkg::ZERO_BYTE;
				alu.write_file = 1'b1;
				alu.update_zero = 1'b1;
			end
			// RQ3 zero the accumulator
			unary_ops_pkg::clear_accumulator_op: begin
				alu.result = unary_ops_pkg::ZERO_BYTE;
				alu.write_acc = 1'b1;
				alu.update_zero = 1'b1;
			end
			// RQ4 plain decrement
			unary_ops_pkg::decrement_file_op: begin
				alu.result = alu.operand - unary_ops_pkg::ONE_BYTE;
				alu.write_acc = (alu.dest == unary_ops_pkg::DEST_ACC);
				alu.write_file = (alu.dest == unary_ops_pkg::DEST_FILE);
				alu.update_zero = 1'b1;
			end
			// RQ5 decrement, flags untouched
			unary_ops_pkg::decrement_skip_zero_op: begin
				alu.result = alu.operand - unary_ops_pkg::ONE_BYTE;
				alu.write_acc = (alu.dest == unary_ops_pkg::DEST_ACC);
				alu.write_file = (alu.dest == unary_ops_pkg::DEST_FILE);
				// RQ6 skip on zero
				alu.skip = (alu.result == unary_ops_pkg::ZERO_BYTE);
			end
			// RQ8 increment, flags untouched
			unary_ops_pkg::increment_skip_zero_op: begin
				alu.result = alu.operand + unary_ops_pkg::ONE_BYTE;
				alu.write_acc = (alu.dest == unary_ops_pkg::DEST_ACC);
				alu.write_file = (alu.dest == unary_ops_pkg::DEST_FILE);
				// RQ9 skip on wrap
				alu.skip = (alu.result == unary_ops_pkg::ZERO_BYTE);
			end
			default: begin
				alu.result = unary_ops_pkg::ZERO_BYTE;
			end
		endcase
	end

	// RQ10 zero exactly on all-zero byte
	assign alu.result_zero = (alu.result == unary_ops_pkg::ZERO_BYTE);

endmodule

// ### pkg/unary_alu_if.sv
// Operand and result bundle between the core and its arithmetic unit
`timescale 1ns/1ps
interface unary_alu_if;
	unary_ops_pkg::op_e op;
	logic dest;
	logic [unary_ops_pkg::DATA_W-1:0] operand;
	logic [unary_ops_pkg::DATA_W-1:0] result;
	logic write_acc;
	logic write_file;
	logic update_zero;
	logic result_zero;
	logic skip;

	modport core (
		output op,
		output dest,
		output operand,
		input result,
		input write_acc,
		input write_file,
		input update_zero,
		input result_zero,
		input skip
	);

	modport calc (
		input op,
		input dest,
		input operand,
		output result,
		output write_acc,
		output write_file,
		output update_zero,
		output result_zero,
		output skip
	);
endinterface

// ### pkg/unary_ops_pkg.sv
// Shared constants and types for the single-operand execution block
package unary_ops_pkg;

	localparam int DATA_W = 8;
	localparam int ADDR_W = 7;
	localparam int FILE_DEPTH = 128;

	localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
	localparam logic [DATA_W-1:0] ONE_BYTE = 8'h01;
	localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
	localparam logic ZERO_FLAG_RESET = 1'b0;

	// Destination select encoding
	localparam logic DEST_ACC = 1'b0;
	localparam logic DEST_FILE = 1'b1;

	// Operation selector presented with each issued instruction
	typedef enum logic [2:0] {
		complement_file_op,
		clear_file_op,
		clear_accumulator_op,
		decrement_file_op,
		decrement_skip_zero_op,
		increment_skip_zero_op,
		no_op
	} op_e;

	// Execution sequencing states
	typedef enum logic [0:0] {
		ST_RUN,
		ST_IDLE_SLOT
	} exec_state_e;

endpackage

// ### tb/file_register_unary_ops_bench.sv
// Self-checking bench for the unary execution block
`timescale 1ns/1ps
module file_register_unary_ops_bench;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic issue_i = 1'b0;
	logic dest_i = 1'b0;
	logic load_en_i = 1'b0;
	logic [6:0] file_addr_i = 7'h00;
	logic [6:0] load_addr_i = 7'h00;
	logic [6:0] peek_addr_i = 7'h00;
	logic [7:0] load_data_i = 8'h00;
	unary_ops_pkg::op_e op_i = unary_ops_pkg::no_op;
	logic [7:0] peek_data_o, acc_o, result_o;
	logic ready_o, zero_flag_o, result_valid_o, idle_slot_o;
	int n_mismatch = 0;
	int n_tests = 0;
	// Status byte: valid, ready, idle, zero
	wire logic [7:0] st = {4'h0, result_valid_o, ready_o, idle_slot_o, zero_flag_o};
	file_register_unary_ops dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .issue_i(issue_i), .op_i(op_i),
		.file_addr_i(file_addr_i), .dest_i(dest_i), .load_en_i(load_en_i), .load_addr_i(load_addr_i),
		.load_data_i(load_data_i), .peek_addr_i(peek_addr_i), .peek_data_o(peek_data_o), .ready_o(ready_o),
		.acc_o(acc_o), .zero_flag_o(zero_flag_o), .result_o(result_o), .result_valid_o(result_valid_o),
		.idle_slot_o(idle_slot_o));
	// 100 MHz clock
	initial begin
		forever #5 clk_i = ~clk_i;
	end
	task chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Tasks start and end at a falling edge; each sets both strobes once and leaves them for the next task
	task ld(input logic [6:0] a, input logic [7:0] d);
		issue_i = 1'b0;
		load_en_i = 1'b1;
		load_addr_i = a;
		load_data_i = d;
		@(negedge clk_i);
	endtask
	task ex(input unary_ops_pkg::op_e op, input logic [6:0] a, input logic d);
		load_en_i = 1'b0;
		issue_i = 1'b1;
		op_i = op;
		file_addr_i = a;
		dest_i = d;
		@(negedge clk_i);
	endtask
	// Peek output lags its address by one cycle
	task pk(input logic [6:0] a);
		issue_i = 1'b0;
		load_en_i = 1'b0;
		peek_addr_i = a;
		@(negedge clk_i);
	endtask
	task t_comp;
		ld(7'h05, 8'h5A);
		ex(unary_ops_pkg::complement_file_op, 7'h05, 1'b0);
		chk(acc_o, 8'hA5);
		chk(result_o, 8'hA5);
		chk(st, 8'h0C);
		ex(unary_ops_pkg::complement_file_op, 7'h05, 1'b1);
		pk(7'h05);
		chk(peek_data_o, 8'hA5);
		ld(7'h06, 8'hFF);
		ex(unary_ops_pkg::complement_file_op, 7'h06, 1'b0);
		chk(st, 8'h0D);
		$display("complement test done");
	endtask
	task t_clear;
		ld(7'h06, 8'h33);
		ex(unary_ops_pkg::clear_file_op, 7'h06, 1'b0);
		chk(st, 8'h0D);
		pk(7'h06);
		chk(peek_data_o, 8'h00);
		ex(unary_ops_pkg::complement_file_op, 7'h05, 1'b0);
		ex(unary_ops_pkg::clear_accumulator_op, 7'h05, 1'b0);
		chk(acc_o, 8'h00);
		chk(st, 8'h0D);
		$display("clear test done");
	endtask
	task t_dec;
		ld(7'h07, 8'h01);
		ex(unary_ops_pkg::decrement_file_op, 7'h07, 1'b1);
		chk(st, 8'h0D);
		pk(7'h07);
		chk(peek_data_o, 8'h00);
		ex(unary_ops_pkg::decrement_file_op, 7'h07, 1'b0);
		chk(acc_o, 8'hFF);
		chk(st, 8'h0C);
		$display("decrement test done");
	endtask
	// Mid-run reset clears the outputs and raises ready at once; file contents survive it
	task t_reset;
		issue_i = 1'b0;
		rst_n_i = 1'b0;
		#1;
		chk(acc_o, 8'h00);
		chk(result_o, 8'h00);
		chk(st, 8'h04);
		@(negedge clk_i);
		rst_n_i = 1'b1;
		$display("reset test done");
	endtask
	// Zero results, a discarded issue, then back-to-back nonzero skips
	task t_skip;
		ld(7'h08, 8'h01);
		ex(unary_ops_pkg::decrement_skip_zero_op, 7'h08, 1'b0);
		chk(acc_o, 8'h00);
		chk(result_o, 8'h00);
		chk(st, 8'h0A);
		ex(unary_ops_pkg::complement_file_op, 7'h08, 1'b0);
		chk(acc_o, 8'h00);
		chk(st, 8'h04);
		ex(unary_ops_pkg::clear_accumulator_op, 7'h00, 1'b0);
		ld(7'h09, 8'hFF);
		ex(unary_ops_pkg::increment_skip_zero_op, 7'h09, 1'b1);
		chk(st, 8'h0B);
		pk(7'h09);
		chk(peek_data_o, 8'h00);
		ld(7'h0A, 8'h05);
		ex(unary_ops_pkg::decrement_skip_zero_op, 7'h0A, 1'b1);
		chk(st, 8'h0D);
		ex(unary_ops_pkg::increment_skip_zero_op, 7'h0A, 1'b0);
		chk(acc_o, 8'h05);
		chk(result_o, 8'h05);
		chk(st, 8'h0D);
		ex(unary_ops_pkg::no_op, 7'h0A, 1'b1);
		chk(acc_o, 8'h05);
		chk(result_o, 8'h00);
		chk(st, 8'h0D);
		pk(7'h0A);
		chk(peek_data_o, 8'h04);
		$display("skip test done");
	endtask
	task results;
		$display("tests %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// Run is about 38 cycles; allow ample margin
	initial begin
		#3000;
		n_mismatch++;
		results;
	end
	initial begin
		repeat (10) @(posedge clk_i);
		@(negedge clk_i);
		rst_n_i = 1'b1;
		t_comp;
		t_clear;
		t_dec;
		t_reset;
		t_skip;
		results;
	end
endmodule

// ### tb/file_register_unary_ops_sva.sv
// Port-level properties of the unary execution block
`timescale 1ns/1ps
module file_register_unary_ops_sva (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic issue_i,
	input wire unary_ops_pkg::op_e op_i,
	input wire logic dest_i,
	input wire logic ready_o,
	input wire logic [7:0] acc_o,
	input wire logic zero_flag_o,
	input wire logic [7:0] result_o,
	input wire logic result_valid_o,
	input wire logic idle_slot_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	// Taken instruction and taken skip
	wire logic tk = issue_i && ready_o;
	wire logic sk = tk && (op_i == unary_ops_pkg::decrement_skip_zero_op || op_i == unary_ops_pkg::increment_skip_zero_op);
	property p_comp; tk && op_i == unary_ops_pkg::complement_file_op && !dest_i |=> acc_o == result_o && zero_flag_o == (result_o == 8'h00); endproperty
	a_comp: assert property (p_comp) else $error("complement result wrong");
	property p_clear_file_op; tk && op_i == unary_ops_pkg::clear_file_op |=> zero_flag_o && result_o == 8'h00; endproperty
	a_clear_file_op: assert property (p_clear_file_op) else $error("clear file wrong");
	property p_clra; tk && op_i == unary_ops_pkg::clear_accumulator_op |=> zero_flag_o && acc_o == 8'h00; endproperty
	a_clra: assert property (p_clra) else $error("clear accumulator wrong");
	property p_dec; tk && op_i == unary_ops_pkg::decrement_file_op && dest_i |=> $stable(acc_o) && zero_flag_o == (result_o == 8'h00); endproperty
	a_dec: assert property (p_dec) else $error("decrement wrong");
	property p_flag; sk |=> $stable(zero_flag_o); endproperty
	a_flag: assert property (p_flag) else $error("skip changed zero flag");
	property p_skip; sk |=> (idle_slot_o == (result_o == 8'h00)) && (ready_o != idle_slot_o); endproperty
	a_skip: assert property (p_skip) else $error("idle slot decision wrong");
	property p_run; sk |=> result_valid_o && ready_o == (result_o != 8'h00); endproperty
	a_run: assert property (p_run) else $error("skip ready wrong");
	property p_idle; idle_slot_o |-> !ready_o ##1 (ready_o && !idle_slot_o); endproperty
	a_idle: assert property (p_idle) else $error("idle slot length wrong");
	property p_ref; issue_i && !ready_o |=> !result_valid_o; endproperty
	a_ref: assert property (p_ref) else $error("discarded issue executed");
endmodule
bind file_register_unary_ops file_register_unary_ops_sva u_sva (.clk_i(clk_i), .rst_n_i(rst_n_i), .issue_i(issue_i),
	.op_i(op_i), .dest_i(dest_i), .ready_o(ready_o), .acc_o(acc_o), .zero_flag_o(zero_flag_o),
	.result_o(result_o), .result_valid_o(result_valid_o), .idle_slot_o(idle_slot_o));
